// file: shared/wdt_pkg.sv
// Package of constants and carrier types for the watchdog interval timer
package wdt_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] CLOCK_SELECT_ADDR  = 16'hFF42;
    localparam logic [15:0] MODE_CONTROL_ADDR  = 16'hFFF9;
    localparam logic [7:0]  CLOCK_SELECT_RESET = 8'h00;
    localparam logic [7:0]  MODE_CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PERIOD_SELECT_LO_POS        = 1;
    localparam int PERIOD_SELECT_HI_POS        = 2;
    localparam int RUN_POS                     = 7;
    localparam int WATCHDOG_MODE_ENABLE_POS    = 4;
    localparam int OVERFLOW_ACTION_SELECT_POS  = 3;
    localparam logic [7:0] CLOCK_SELECT_MASK   = 8'h06;
    localparam logic [7:0] MODE_CONTROL_MASK   = 8'h98;

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    localparam int          PRESCALE_WIDTH = 10;
    localparam int          COUNT_WIDTH    = 7;
    localparam logic [6:0]  COUNT_RESET    = 7'h00;
    localparam logic [9:0]  PRESCALE_RESET = 10'h000;

    // Overflow times in main clock cycles per period code
    localparam int OVERFLOW_CYCLES_0 = 2048;
    localparam int OVERFLOW_CYCLES_3 = 131072;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WDT_STOPPED  = 2'b00,
        WDT_INTERVAL = 2'b01,
        WDT_NMI      = 2'b10,
        WDT_RESET    = 2'b11
    } wdt_mode_type;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [15:0] addr;
        logic [7:0] wdata;
    } wdt_access_type;

    typedef struct packed {
        logic irq_flag_set;
        logic nmi;
        logic reset_request;
    } wdt_event_type;

endpackage

// file: testbench/test_wdt_timer.sv
// Self-checking testbench for the watchdog interval timer
`timescale 1ns/1ns
module test_wdt_timer;
    import wdt_pkg::*;
    logic           ref_clk = 1'b0;
    logic           rst = 1'b1;
    wdt_access_type acc = '0;
    logic [7:0]     rdata;
    logic           stop_mode = 1'b0;
    logic           sub_clk = 1'b0;
    logic           sw_set = 1'b0;
    logic           mask_in = 1'b0;
    logic           flag;
    logic           mask;
    wdt_event_type  ev;
    logic           irq_req;
    int             fail_count = 0;
    int             tests_run = 0;
    int             n;
    always #2 ref_clk = ~ref_clk;
    wdt_timer uut (.ref_clk(ref_clk), .rst(rst), .access(acc),
        .read_data(rdata), .stop_mode(stop_mode),
        .subsystem_clock_cpu(sub_clk), .wdog_irq_flag(flag),
        .wdog_irq_mask(mask), .events(ev), .interval_irq_request(irq_req));
    wdt_irq_model cpu (.ref_clk(ref_clk), .rst(rst), .irq_set(ev.irq_flag_set),
        .sw_set(sw_set), .mask_in(mask_in), .flag(flag), .mask(mask));
    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", w, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        acc <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        acc <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string w);
        @(posedge ref_clk);
        acc <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        acc <= '0;
        #1;
        chk(w, e, rdata);
    endtask
    task automatic wait_ev(input int b, input int lim);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (ev[b] !== 1'b1 && n < lim);
    endtask
    task automatic reset_dut;
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        reset_dut();
        rd(CLOCK_SELECT_ADDR, CLOCK_SELECT_RESET, "clock select");
        rd(MODE_CONTROL_ADDR, MODE_CONTROL_RESET, "mode control");
        rd(16'hFF43, 8'h00, "unmapped");
        wr(CLOCK_SELECT_ADDR, 8'hFF);
        rd(CLOCK_SELECT_ADDR, 8'h06, "select field");
        wr(CLOCK_SELECT_ADDR, 8'h00);
        wr(MODE_CONTROL_ADDR, 8'h08);
        wait_ev(2, 3000);
        chk("idle without run", 3000, n);
        wr(MODE_CONTROL_ADDR, 8'h88);
        wait_ev(2, 2100);
        chk("first interval", 1, n >= 2032 && n <= 2050);
        chk("interval request", 1'b1, irq_req);
        wait_ev(2, 2100);
        chk("interval period", 2048, n);
        @(posedge ref_clk);
        mask_in <= 1'b1;
        wait_ev(2, 2100);
        chk("masked request", 1'b0, irq_req);
        wr(MODE_CONTROL_ADDR, 8'h00);
        rd(MODE_CONTROL_ADDR, 8'h88, "run sticky");
        for (int c = 1; c < 3; c++) begin
            reset_dut();
            wr(CLOCK_SELECT_ADDR, 8'(c << 1));
            wr(MODE_CONTROL_ADDR, 8'h88);
            wait_ev(2, 40000);
            chk("coded interval", 1, n >= (2048 << 2 * c) * 127 / 128
                && n <= (2048 << 2 * c) + 2);
        end
        reset_dut();
        wr(MODE_CONTROL_ADDR, 8'h90);
        repeat (2) begin
            wait_ev(1, 1500);
            chk("nmi held off", 1500, n);
            wr(MODE_CONTROL_ADDR, 8'h80);
        end
        wait_ev(1, 2100);
        chk("nmi overflow", 1, n >= 2032 && n <= 2050);
        wr(MODE_CONTROL_ADDR, 8'h08);
        rd(MODE_CONTROL_ADDR, 8'h98, "no interval return");
        wait_ev(0, 2100);
        chk("reset overflow", 1, n < 2100);
        reset_dut();
        @(posedge ref_clk);
        sw_set <= 1'b1;
        @(posedge ref_clk);
        sw_set <= 1'b0;
        wr(MODE_CONTROL_ADDR, 8'h10);
        #1;
        chk("flag nmi", 1'b1, ev.nmi);
        for (int k = 0; k < 2; k++) begin
            reset_dut();
            wr(MODE_CONTROL_ADDR, 8'h88);
            stop_mode <= k == 0;
            sub_clk <= k == 1;
            wait_ev(2, 3000);
            chk("frozen count", 3000, n);
            @(posedge ref_clk);
            stop_mode <= 1'b0;
            sub_clk <= 1'b0;
            wait_ev(2, 2100);
            chk("count resumes", 1, n < 2100);
        end
        end_of_test();
    end
    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end
endmodule // test_wdt_timer

// file: testbench/wdt_checker.sv
// Port assertions for the watchdog interval timer
`timescale 1ns/1ns
module wdt_checker (
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rst,
    // Ports watched
    input wire wdt_pkg::wdt_access_type access,
    input wire logic [7:0]              read_data,
    input wire logic                    stop_mode,
    input wire logic                    subsystem_clock_cpu,
    input wire logic                    wdog_irq_flag,
    input wire logic                    wdog_irq_mask,
    input wire wdt_pkg::wdt_event_type  events,
    input wire logic                    interval_irq_request
);
    import wdt_pkg::*;
    logic [1:0]  mode_seen;
    logic [11:0] gap;
    logic        mode_wr;
    assign mode_wr = access.write && access.addr == MODE_CONTROL_ADDR;
    always_ff @(posedge ref_clk) begin
        if (rst) mode_seen <= 2'b00;
        else if (mode_wr) mode_seen <= mode_seen | access.wdata[4:3];
    end
    always_ff @(posedge ref_clk) begin
        if (rst) gap <= 12'hFFF;
        else if (events.irq_flag_set) gap <= 12'h000;
        else if (gap != 12'hFFF) gap <= gap + 12'h001;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (
        $fell(rst) |-> events == 3'b000 && read_data == 8'h00)
        else $error("outputs not quiet after reset");
    a_select_zeros: assert property (
        access.read && access.addr == CLOCK_SELECT_ADDR
        |=> (read_data & ~CLOCK_SELECT_MASK) == 8'h00)
        else $error("clock select unused bits set");
    a_mode_sticky: assert property (
        access.read && access.addr == MODE_CONTROL_ADDR
        |=> read_data[4:3] == mode_seen && read_data[2:0] == 3'h0)
        else $error("mode bits read wrong");
    a_irq_mode: assert property (
        events.irq_flag_set |-> mode_seen == 2'b01)
        else $error("interval event outside interval mode");
    a_nmi_mode: assert property (
        events.nmi |-> mode_seen == 2'b10)
        else $error("nmi outside nmi mode");
    a_reset_mode: assert property (
        events.reset_request |-> mode_seen == 2'b11)
        else $error("reset request outside reset mode");
    a_flag_nmi: assert property (
        mode_wr && access.wdata[4:3] == 2'b10 && !mode_seen[0]
        && wdog_irq_flag |=> events.nmi)
        else $error("flag nmi missing");
    a_event_pulse: assert property (
        events != 3'b000 |=> events == 3'b000)
        else $error("event longer than one cycle");
    a_irq_gated: assert property (
        interval_irq_request |-> events.irq_flag_set)
        else $error("request without overflow");
    a_irq_spacing: assert property (
        events.irq_flag_set |-> gap >= 12'd2047)
        else $error("interval overflow too soon");
    a_stop_freeze: assert property (
        stop_mode [*4] |-> !events.irq_flag_set && !events.reset_request)
        else $error("overflow during stop");
    a_subsys_freeze: assert property (
        subsystem_clock_cpu [*4]
        |-> !events.irq_flag_set && !events.reset_request)
        else $error("overflow on subsystem clock");
endmodule // wdt_checker

bind wdt_timer wdt_checker chk (.ref_clk(ref_clk), .rst(rst),
    .access(access), .read_data(read_data), .stop_mode(stop_mode),
    .subsystem_clock_cpu(subsystem_clock_cpu), .wdog_irq_flag(wdog_irq_flag),
    .wdog_irq_mask(wdog_irq_mask), .events(events),
    .interval_irq_request(interval_irq_request));

// file: testbench/wdt_irq_model.sv
// Interrupt controller model holding the watchdog flag and mask
`timescale 1ns/1ns
module wdt_irq_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Flag and mask sources
    input  wire logic irq_set,
    input  wire logic sw_set,
    input  wire logic mask_in,
    // To the timer
    output logic      flag,
    output logic      mask
);
    import wdt_pkg::*;
    always_ff @(posedge ref_clk) begin
        if (rst) flag <= 1'b0;
        else if (irq_set || sw_set) flag <= 1'b1;
    end
    always_ff @(posedge ref_clk) begin
        mask <= rst ? 1'b1 : mask_in;
    end
endmodule // wdt_irq_model

// file: verilog/wdt_prescaler.sv
// Main clock prescaler, counting only while count_enable is high, with count tick select
`timescale 1ns/1ns
module wdt_prescaler (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       count_enable,
    input  wire logic [1:0] period_select,
    // Tick out
    output logic            count_tick
);
    import wdt_pkg::*;

    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [PRESCALE_WIDTH-1:0] next_prescale;
    logic                      tap;

    // ------------------------------------------------------------------
    // Divider, never cleared by the run bit
    // ------------------------------------------------------------------
    assign next_prescale = prescale + 10'h001;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prescale <= PRESCALE_RESET;
        end else if (count_enable) begin
            prescale <= next_prescale;
        end
    end

    // Tick at divide by 16, 64, 256 or 1024
    always_comb begin
        case (period_select)
            2'b00:   tap = (prescale[3:0] == 4'hF);
            2'b01:   tap = (prescale[5:0] == 6'h3F);
            2'b10:   tap = (prescale[7:0] == 8'hFF);
            2'b11:   tap = (prescale == 10'h3FF);
            default: tap = 1'b0;
        endcase
    end

    assign count_tick = tap & count_enable;

endmodule // wdt_prescaler

// file: verilog/wdt_timer.sv
// Watchdog and interval timer with its two control registers
//
// Operation
// - Period select picks main clock /16,/64,/256,/1024; overflow after 2^11..2^17.
// - Writing run bit 1 clears counter and starts counting; writing run 0 is ignored.
// - Run bit cannot be cleared by software; only system reset clears it.
// - Mode bits 4,3: stopped, interval, nonmaskable interrupt, system reset.
// - Mode bits, once set, ignore clears; watchdog mode blocks interval mode.
// - System reset clears both registers to 00H.
// - Watchdog overflow raises nonmaskable interrupt or reset per bit 3.
// - Interval mode raises maskable request at every overflow, mask applies.
// - Interval request has highest maskable priority in the controller.
// - First overflow after restart may be up to 0.8% early.
// - Flag set when nonmaskable interrupt mode (bits 4,3 = 10) written raises nonmaskable interrupt.
// - Counting continues in halt, freezes in stop power state.
// - Counting stops while CPU runs from subsystem clock.
`timescale 1ns/1ns
module wdt_timer (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Register access from the CPU
    input  wire wdt_pkg::wdt_access_type access,
    output logic [7:0]                   read_data,
    // CPU power and clock state
    input  wire logic                    stop_mode,
    input  wire logic                    subsystem_clock_cpu,
    // Interrupt controller side
    input  wire logic                    wdog_irq_flag,
    input  wire logic                    wdog_irq_mask,
    // Overflow events
    output wdt_pkg::wdt_event_type       events,
    output logic                         interval_irq_request
);
    import wdt_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]             wdog_clock_select;
    logic                   run;
    logic                   watchdog_mode_enable;
    logic                   overflow_action_select;
    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH:0]   next_count;
    logic                   count_tick;
    logic                   count_enable;
    logic                   overflow;
    logic                   clock_write;
    logic                   mode_write;
    logic                   run_write;
    logic                   flag_nmi;
    logic [1:0]             async_in;
    logic [1:0]             async_meta;
    logic [1:0]             async_sync;
    logic                   stop_sync;
    logic                   sub_sync;
    logic                   clock_read;
    logic                   mode_read;
    logic [7:0]             next_read_data;
    wdt_mode_type           mode;
    wdt_event_type          next_events;

    assign clock_write = access.write & (access.addr == CLOCK_SELECT_ADDR);
    assign mode_write  = access.write & (access.addr == MODE_CONTROL_ADDR);
    assign run_write   = mode_write & access.wdata[RUN_POS];
    assign mode        = wdt_mode_type'({watchdog_mode_enable,
                                         overflow_action_select});

    // ------------------------------------------------------------------
    // Power state inputs, synchronised
    // ------------------------------------------------------------------
    assign async_in = {subsystem_clock_cpu, stop_mode};

    // Two flip-flops per asynchronous input
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                async_meta[i] <= 1'b0;
                async_sync[i] <= 1'b0;
            end else begin
                async_meta[i] <= async_in[i];
                async_sync[i] <= async_meta[i];
            end
        end
    end

    assign stop_sync = async_sync[0];
    assign sub_sync  = async_sync[1];

    // Halt keeps counting; stop and subsystem clock freeze it
    assign count_enable = run & ~stop_sync & ~sub_sync;

    // ------------------------------------------------------------------
    // Clock select register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wdog_clock_select <= CLOCK_SELECT_RESET;
        end else if (clock_write) begin
            wdog_clock_select <= access.wdata & CLOCK_SELECT_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Mode control register, bits only settable
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run                    <= MODE_CONTROL_RESET[RUN_POS];
            watchdog_mode_enable   <=
                MODE_CONTROL_RESET[WATCHDOG_MODE_ENABLE_POS];
            overflow_action_select <=
                MODE_CONTROL_RESET[OVERFLOW_ACTION_SELECT_POS];
        end else if (mode_write) begin
            run <= run | access.wdata[RUN_POS];
            watchdog_mode_enable <= watchdog_mode_enable
                | access.wdata[WATCHDOG_MODE_ENABLE_POS];
            overflow_action_select <= overflow_action_select
                | access.wdata[OVERFLOW_ACTION_SELECT_POS];
        end
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    wdt_prescaler u_prescaler (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .count_enable  (count_enable),
        .period_select (wdog_clock_select[PERIOD_SELECT_HI_POS:
                                          PERIOD_SELECT_LO_POS]),
        .count_tick    (count_tick)
    );

    // ------------------------------------------------------------------
    // Seven-bit counter, cleared by a run write
    // ------------------------------------------------------------------
    assign next_count = {1'b0, count} + 8'h01;
    assign overflow   = count_tick & next_count[COUNT_WIDTH] &
                        ~run_write;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= COUNT_RESET;
        end else if (run_write) begin
            count <= COUNT_RESET;
        end else if (count_tick) begin
            count <= next_count[COUNT_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Overflow events
    // ------------------------------------------------------------------
    // Pending flag at a nonmaskable interrupt mode write (bit 4 set, bit 3 clear) raises a nonmaskable interrupt
    assign flag_nmi = mode_write & wdog_irq_flag &
                      access.wdata[WATCHDOG_MODE_ENABLE_POS] &
                      ~access.wdata[OVERFLOW_ACTION_SELECT_POS] &
                      ~overflow_action_select;

    always_comb begin
        next_events = '0;
        case (mode)
            WDT_INTERVAL: next_events.irq_flag_set  = overflow;
            WDT_NMI:      next_events.nmi           = overflow;
            WDT_RESET:    next_events.reset_request = overflow;
            default:      next_events = '0;
        endcase
        next_events.nmi = next_events.nmi | flag_nmi;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            events <= '0;
        end else begin
            events <= next_events;
        end
    end

    // ------------------------------------------------------------------
    // Maskable interval request
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            interval_irq_request <= 1'b0;
        end else begin
            // Highest maskable priority is given in the controller
            interval_irq_request <= next_events.irq_flag_set &
                                    ~wdog_irq_mask;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    assign clock_read = access.read & (access.addr == CLOCK_SELECT_ADDR);
    assign mode_read  = access.read & (access.addr == MODE_CONTROL_ADDR);

    // Unmapped or idle cycles read zero
    always_comb begin
        case ({clock_read, mode_read})
            2'b10: begin
                next_read_data = wdog_clock_select;
            end
            2'b01: begin
                next_read_data = {run, 2'b00, watchdog_mode_enable,
                                  overflow_action_select, 3'b000};
            end
            default: begin
                next_read_data = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            read_data <= 8'h00;
        end else begin
            read_data <= next_read_data;
        end
    end

endmodule // wdt_timer
